// file: rtl/toc_cmp_chan.v
// One output compare channel: value register, write inhibit and match
`timescale 1ns/1ps
`include "toc_timer_regs.vh"

module toc_cmp_chan (
	// Clock and reset
	input  wire        hclk,
	input  wire        hresetn,
	// Counter side
	input  wire [15:0] count,
	input  wire        tick,
	// Software writes
	input  wire        wr_high,
	input  wire        wr_low,
	input  wire [7:0]  wdata,
	// Results
	output reg  [15:0] value_reg,
	output reg         match_reg
);

	reg inhibit_reg;

	////////////////////////////////////////////////////////////////////
	// Only software writes change the value; hardware never does
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			value_reg   <= `TOC_CMP_RESET; // [RULE2]
			inhibit_reg <= 1'b0;
		end else begin
			if (wr_high) begin
				value_reg[15:8] <= wdata;
				inhibit_reg     <= 1'b1; // [RULE7]
			end
			if (wr_low) begin
				value_reg[7:0] <= wdata;
				inhibit_reg    <= 1'b0; // [RULE7]
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// One match per timer clock cycle while the counter holds the value
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			match_reg <= 1'b0;
		end else begin
			match_reg <= tick & ~inhibit_reg & ~wr_high &
				(count == value_reg); // [RULE1]
		end
	end

endmodule // toc_cmp_chan

// file: rtl/toc_timer_compare.v
// Timer output compare and one pulse unit with an AHB-Lite register port
// Operation
// [RULE1] Two 16-bit compare values checked against the counter each tick.
// [RULE2] Compare values reset to 8000h; only software changes them.
// [RULE3] Match sets its flag and drives its level if pin enabled.
// [RULE4] Compare pin latches are low during reset.
// [RULE5] Compare interrupt needs enable set and global mask clear.
// [RULE6] Compare flag clears: status read seeing it, then low-byte access.
// [RULE7] High-byte write stops compares until the low byte is written.
// [RULE8] Software should write high byte, read status, write low byte.
// [RULE9] Pin disabled: no level driven on match, interrupt still possible. In one pulse mode pin one is driven on trigger and match regardless.
// [RULE10] Forced bit copies level to pin, no flag, no interrupt.
// [RULE11] Forced bits ignored in one pulse or PWM mode.
// [RULE12] One-pulse select enters mode using capture one and compare one.
// [RULE13] Trigger edge: counter FFFCh, pin one gets level two, capture FFFDh.
// [RULE14] Trigger capture flag raises interrupt when capture enable set.
// [RULE15] Capture flag clears: status read seeing it, then low-byte access.
// [RULE16] In one pulse, compare one match puts level one on pin one.
// [RULE17] One pulse never sets compare flag one; flag two still works.
// [RULE18] PWM and one-pulse both set: only PWM mode acts.
// [RULE19] One pulse: capture one inactive, capture two still captures.
// [RULE20] One pulse: compare two flags only, drives no waveform.
// [RULE21] Timer clock is CPU clock over 2, 4, 8, or external.
// [RULE22] Counter resets and reloads only to FFFCh in every mode.
// [RULE23] Compare pins hold their level until match, force or reset.
`timescale 1ns/1ps
`include "toc_timer_regs.vh"

module toc_timer_compare (
	// Clock and reset
	input  wire        hclk,
	input  wire        hresetn,
	// AHB-Lite slave
	input  wire        hsel,
	input  wire [7:0]  haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg         hreadyout,
	output reg         hresp,
	output reg  [31:0] hrdata,
	// Pins and CPU mask
	input  wire        capture_input_pin_one,
	input  wire        capture_input_pin_two,
	input  wire        ext_clock_pin,
	input  wire        cpu_irq_mask,
	output reg         compare_output_pin_one,
	output reg         compare_output_pin_one_oe,
	output reg         compare_output_pin_two,
	output reg         compare_output_pin_two_oe,
	output reg         timer_irq_reg
);

	// Registers
	reg  [7:0]  timer_control_one;
	reg  [7:0]  timer_control_two;
	reg  [15:0] free_counter_value;
	reg  [15:0] capture_value_one;
	reg  [15:0] capture_value_two;
	reg  [2:0]  div_reg;
	reg  [2:0]  cap1_sync_reg;
	reg  [2:0]  cap2_sync_reg;
	reg  [2:0]  ext_sync_reg;
	reg         cap1_inhibit_reg;
	reg         cap2_inhibit_reg;
	reg         capture_flag_one;
	reg         capture_flag_two;
	reg         cmp_flag_one;
	reg         cmp_flag_two;
	reg         arm_cap1_reg;
	reg         arm_cap2_reg;
	reg         arm_cmp1_reg;
	reg         arm_cmp2_reg;
	reg         dp_write_reg;
	reg  [7:0]  dp_addr_reg;
	reg  [7:0]  rd_next;
	reg  [2:0]  div_mask;
	reg         tick;

	// Bus decode
	wire        ap_valid = hsel & htrans[1] & hready;
	wire        ap_read  = ap_valid & ~hwrite;
	wire        dp_wr    = dp_write_reg;
	wire [7:0]  wbyte    = hwdata[7:0];

	function rd_at;
		input [7:0] a;
		input [7:0] off;
		begin
			rd_at = ap_read & (a == off);
		end
	endfunction

	function wr_at;
		input [7:0] off;
		begin
			wr_at = dp_wr & (dp_addr_reg == off);
		end
	endfunction

	wire wr_c1    = wr_at(`TOC_OFF_CTRL_ONE);
	wire wr_c2    = wr_at(`TOC_OFF_CTRL_TWO);
	wire wr_m1_hi = wr_at(`TOC_OFF_CMP1_HI);
	wire wr_m1_lo = wr_at(`TOC_OFF_CMP1_LO);
	wire wr_m2_hi = wr_at(`TOC_OFF_CMP2_HI);
	wire wr_m2_lo = wr_at(`TOC_OFF_CMP2_LO);
	wire wr_cnt   = wr_at(`TOC_OFF_CNT_LO);
	wire rd_sr    = rd_at(haddr, `TOC_OFF_STATUS);
	wire rd_k1_hi = rd_at(haddr, `TOC_OFF_CAP1_HI);
	wire rd_k2_hi = rd_at(haddr, `TOC_OFF_CAP2_HI);
	wire acc_k1_lo = rd_at(haddr, `TOC_OFF_CAP1_LO) |
		wr_at(`TOC_OFF_CAP1_LO);
	wire acc_k2_lo = rd_at(haddr, `TOC_OFF_CAP2_LO) |
		wr_at(`TOC_OFF_CAP2_LO);
	wire acc_m1_lo = rd_at(haddr, `TOC_OFF_CMP1_LO) | wr_m1_lo;
	wire acc_m2_lo = rd_at(haddr, `TOC_OFF_CMP2_LO) | wr_m2_lo;

	// Mode decode
	wire pwm_mode = timer_control_two[`TOC_C2_PWM];
	wire opm_mode = timer_control_two[`TOC_C2_ONE_PULSE] &
		~pwm_mode; // [RULE12] [RULE18]
	wire [1:0] pre_sel = timer_control_two[`TOC_C2_PRE_HI:
		`TOC_C2_PRE_LO];
	wire force1 = wr_c1 & wbyte[`TOC_C1_FORCE1] &
		~opm_mode & ~pwm_mode; // [RULE10] [RULE11]
	wire force2 = wr_c1 & wbyte[`TOC_C1_FORCE2] &
		~opm_mode & ~pwm_mode; // [RULE10] [RULE11]
	wire level1 = timer_control_one[`TOC_C1_LEVEL1];
	wire level2 = timer_control_one[`TOC_C1_LEVEL2];

	////////////////////////////////////////////////////////////////////
	// Pin synchronisers; only the second and third stages are read
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cap1_sync_reg <= 3'h0;
			cap2_sync_reg <= 3'h0;
			ext_sync_reg  <= 3'h0;
		end else begin
			cap1_sync_reg <= {cap1_sync_reg[1:0],
				capture_input_pin_one};
			cap2_sync_reg <= {cap2_sync_reg[1:0],
				capture_input_pin_two};
			ext_sync_reg  <= {ext_sync_reg[1:0], ext_clock_pin};
		end
	end

	// Edge select bit set means rising edge is active
	wire cap1_edge = timer_control_one[`TOC_C1_EDGE1] ?
		(cap1_sync_reg[1] & ~cap1_sync_reg[2]) :
		(~cap1_sync_reg[1] & cap1_sync_reg[2]);
	wire cap2_edge = timer_control_two[`TOC_C2_EDGE2] ?
		(cap2_sync_reg[1] & ~cap2_sync_reg[2]) :
		(~cap2_sync_reg[1] & cap2_sync_reg[2]);
	wire ext_edge = timer_control_two[`TOC_C2_EXT_EDGE] ?
		(ext_sync_reg[1] & ~ext_sync_reg[2]) :
		(~ext_sync_reg[1] & ext_sync_reg[2]);

	// Trigger and capture events; PWM disconnects capture one
	wire opm_trigger = opm_mode & cap1_edge; // [RULE13]
	wire cap1_event  = cap1_edge & ~opm_mode & ~pwm_mode &
		~cap1_inhibit_reg; // [RULE19]
	wire cap2_event  = cap2_edge & ~cap2_inhibit_reg; // [RULE19]

	////////////////////////////////////////////////////////////////////
	// Timer clock: prescaled CPU clock or external edge
	always @* begin
		case (pre_sel)
		`TOC_PRE_DIV2: div_mask = `TOC_MASK_DIV2;
		`TOC_PRE_DIV8: div_mask = `TOC_MASK_DIV8;
		default:       div_mask = `TOC_MASK_DIV4;
		endcase
		if (pre_sel == `TOC_PRE_EXT) begin
			tick = ext_edge; // [RULE21]
		end else begin
			tick = ((div_reg & div_mask) == div_mask); // [RULE21]
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_reg <= 3'h0;
		end else begin
			div_reg <= div_reg + 3'h1;
		end
	end

	// Counter reloads only to FFFCh: reset, low-byte write, trigger
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			free_counter_value <= `TOC_CNT_RELOAD; // [RULE22]
		end else if (opm_trigger | wr_cnt) begin
			free_counter_value <= `TOC_CNT_RELOAD; // [RULE13] [RULE22]
		end else if (tick) begin
			free_counter_value <= free_counter_value + 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Compare channels
	wire [15:0] compare_value_one;
	wire [15:0] compare_value_two;
	wire        match1;
	wire        match2;

	toc_cmp_chan u_cmp1 (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.count     (free_counter_value),
		.tick      (tick),
		.wr_high   (wr_m1_hi),
		.wr_low    (wr_m1_lo),
		.wdata     (wbyte),
		.value_reg (compare_value_one),
		.match_reg (match1)
	);

	toc_cmp_chan u_cmp2 (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.count     (free_counter_value),
		.tick      (tick),
		.wr_high   (wr_m2_hi),
		.wr_low    (wr_m2_lo),
		.wdata     (wbyte),
		.value_reg (compare_value_two),
		.match_reg (match2)
	);

	// Flag sources; PWM inhibits compare flags entirely
	wire set_cmp1 = match1 & ~opm_mode & ~pwm_mode; // [RULE3] [RULE17]
	wire set_cmp2 = match2 & ~pwm_mode; // [RULE3] [RULE17] [RULE20]
	wire set_cap1 = cap1_event | opm_trigger; // [RULE13]

	////////////////////////////////////////////////////////////////////
	// Control registers
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			timer_control_one <= `TOC_CTRL_RESET;
			timer_control_two <= `TOC_CTRL_RESET;
		end else begin
			if (wr_c1) begin
				timer_control_one <= wbyte & `TOC_C1_RD_MASK;
			end
			if (wr_c2) begin
				timer_control_two <= wbyte;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Capture values; a high-byte read blocks counter captures until low is read or written
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			capture_value_one <= `TOC_ZERO16;
			capture_value_two <= `TOC_ZERO16;
			cap1_inhibit_reg  <= 1'b0;
			cap2_inhibit_reg  <= 1'b0;
		end else begin
			if (opm_trigger) begin
				capture_value_one <= `TOC_CAP_PULSE; // [RULE13]
			end else if (cap1_event) begin
				capture_value_one <= free_counter_value;
			end
			if (cap2_event) begin
				capture_value_two <= free_counter_value; // [RULE19]
			end
			if (rd_k1_hi) begin
				cap1_inhibit_reg <= 1'b1;
			end else if (acc_k1_lo) begin
				cap1_inhibit_reg <= 1'b0;
			end
			if (rd_k2_hi) begin
				cap2_inhibit_reg <= 1'b1;
			end else if (acc_k2_lo) begin
				cap2_inhibit_reg <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Status flags: a new set always wins over a clear in one cycle
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cmp_flag_one     <= 1'b0;
			cmp_flag_two     <= 1'b0;
			capture_flag_one <= 1'b0;
			capture_flag_two <= 1'b0;
			arm_cmp1_reg     <= 1'b0;
			arm_cmp2_reg     <= 1'b0;
			arm_cap1_reg     <= 1'b0;
			arm_cap2_reg     <= 1'b0;
		end else begin
			cmp_flag_one <= set_cmp1 |
				(cmp_flag_one & ~(arm_cmp1_reg & acc_m1_lo)); // [RULE6]
			cmp_flag_two <= set_cmp2 |
				(cmp_flag_two & ~(arm_cmp2_reg & acc_m2_lo)); // [RULE6]
			capture_flag_one <= set_cap1 | (capture_flag_one &
				~(arm_cap1_reg & acc_k1_lo)); // [RULE15]
			capture_flag_two <= cap2_event | (capture_flag_two &
				~(arm_cap2_reg & acc_k2_lo)); // [RULE15]
			arm_cmp1_reg <= (rd_sr & cmp_flag_one) |
				(arm_cmp1_reg & ~acc_m1_lo); // [RULE6]
			arm_cmp2_reg <= (rd_sr & cmp_flag_two) |
				(arm_cmp2_reg & ~acc_m2_lo); // [RULE6]
			arm_cap1_reg <= (rd_sr & capture_flag_one) |
				(arm_cap1_reg & ~acc_k1_lo); // [RULE15]
			arm_cap2_reg <= (rd_sr & capture_flag_two) |
				(arm_cap2_reg & ~acc_k2_lo); // [RULE15]
		end
	end

	////////////////////////////////////////////////////////////////////
	// Compare pins hold their level between events
	always @(posedge hclk or negedge hresetn) begin // [RULE23]
		if (!hresetn) begin
			compare_output_pin_one    <= 1'b0; // [RULE4]
			compare_output_pin_two    <= 1'b0; // [RULE4]
			compare_output_pin_one_oe <= 1'b0;
			compare_output_pin_two_oe <= 1'b0;
		end else begin
			compare_output_pin_one_oe <=
				timer_control_two[`TOC_C2_PIN1_EN]; // [RULE9]
			compare_output_pin_two_oe <=
				timer_control_two[`TOC_C2_PIN2_EN]; // [RULE9]
			// Trigger beats a same-cycle match so a pulse always starts
			if (opm_trigger) begin
				compare_output_pin_one <= level2; // [RULE13]
			end else if (opm_mode & match1) begin
				compare_output_pin_one <= level1; // [RULE16]
			end else if (force1) begin
				// Level written with the strobe is the one copied
				compare_output_pin_one <= wbyte[`TOC_C1_LEVEL1]; // [RULE10]
			end else if (set_cmp1 &
				timer_control_two[`TOC_C2_PIN1_EN]) begin
				compare_output_pin_one <= level1; // [RULE3] [RULE9]
			end
			// Level two belongs to the pulse in one pulse mode
			if (force2) begin
				compare_output_pin_two <= wbyte[`TOC_C1_LEVEL2]; // [RULE10]
			end else if (set_cmp2 & ~opm_mode &
				timer_control_two[`TOC_C2_PIN2_EN]) begin
				compare_output_pin_two <= level2; // [RULE3] [RULE20]
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Timer interrupt stays pending until both enables allow it
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			timer_irq_reg <= 1'b0;
		end else begin
			timer_irq_reg <= ~cpu_irq_mask & (
				(timer_control_one[`TOC_C1_CMP_IE] &
				(cmp_flag_one | cmp_flag_two)) | // [RULE5]
				(timer_control_one[`TOC_C1_CAP_IE] &
				(capture_flag_one | capture_flag_two))); // [RULE14]
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read data is chosen in the address phase and held in a flop
	always @* begin
		case (haddr)
		`TOC_OFF_CTRL_ONE: rd_next = timer_control_one;
		`TOC_OFF_CTRL_TWO: rd_next = timer_control_two;
		`TOC_OFF_STATUS: begin
			rd_next = `TOC_ZERO8;
			rd_next[`TOC_SR_CAP1] = capture_flag_one;
			rd_next[`TOC_SR_CMP1] = cmp_flag_one;
			rd_next[`TOC_SR_CAP2] = capture_flag_two;
			rd_next[`TOC_SR_CMP2] = cmp_flag_two;
		end
		`TOC_OFF_CAP1_HI: rd_next = capture_value_one[15:8];
		`TOC_OFF_CAP1_LO: rd_next = capture_value_one[7:0];
		`TOC_OFF_CAP2_HI: rd_next = capture_value_two[15:8];
		`TOC_OFF_CAP2_LO: rd_next = capture_value_two[7:0];
		`TOC_OFF_CMP1_HI: rd_next = compare_value_one[15:8];
		`TOC_OFF_CMP1_LO: rd_next = compare_value_one[7:0];
		`TOC_OFF_CMP2_HI: rd_next = compare_value_two[15:8];
		`TOC_OFF_CMP2_LO: rd_next = compare_value_two[7:0];
		`TOC_OFF_CNT_HI:  rd_next = free_counter_value[15:8];
		`TOC_OFF_CNT_LO:  rd_next = free_counter_value[7:0];
		default:          rd_next = `TOC_ZERO8;
		endcase
	end

	// Zero wait states; unmapped addresses read zero and ignore writes
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout    <= 1'b1;
			hresp        <= 1'b0;
			hrdata       <= 32'h00000000;
			dp_write_reg <= 1'b0;
			dp_addr_reg  <= `TOC_ZERO8;
		end else begin
			hreadyout    <= 1'b1;
			hresp        <= 1'b0;
			dp_write_reg <= ap_valid & hwrite;
			if (ap_valid) begin
				dp_addr_reg <= haddr;
			end
			if (ap_read) begin
				hrdata <= {24'h000000, rd_next};
			end
		end
	end

endmodule // toc_timer_compare

// file: rtl/toc_timer_regs.vh
// Register map, field positions and constants of the timer compare block
`ifndef TOC_TIMER_REGS_VH
`define TOC_TIMER_REGS_VH

// Byte addresses of the word-aligned registers
`define TOC_ADDR_W        8
`define TOC_OFF_CTRL_TWO  8'h00
`define TOC_OFF_CTRL_ONE  8'h04
`define TOC_OFF_STATUS    8'h08
`define TOC_OFF_CAP1_HI   8'h0C
`define TOC_OFF_CAP1_LO   8'h10
`define TOC_OFF_CMP1_HI   8'h14
`define TOC_OFF_CMP1_LO   8'h18
`define TOC_OFF_CNT_HI    8'h1C
`define TOC_OFF_CNT_LO    8'h20
`define TOC_OFF_CAP2_HI   8'h24
`define TOC_OFF_CAP2_LO   8'h28
`define TOC_OFF_CMP2_HI   8'h2C
`define TOC_OFF_CMP2_LO   8'h30

// Control one fields
`define TOC_C1_CAP_IE     7
`define TOC_C1_CMP_IE     6
`define TOC_C1_FORCE2     4
`define TOC_C1_FORCE1     3
`define TOC_C1_LEVEL2     2
`define TOC_C1_EDGE1      1
`define TOC_C1_LEVEL1     0
// Forced-level bits are strobes and read back as zero
`define TOC_C1_RD_MASK    8'hC7

// Control two fields
`define TOC_C2_PIN1_EN    7
`define TOC_C2_PIN2_EN    6
`define TOC_C2_ONE_PULSE  5
`define TOC_C2_PWM        4
`define TOC_C2_PRE_HI     3
`define TOC_C2_PRE_LO     2
`define TOC_C2_EDGE2      1
`define TOC_C2_EXT_EDGE   0

// Status fields
`define TOC_SR_CAP1       7
`define TOC_SR_CMP1       6
`define TOC_SR_CAP2       4
`define TOC_SR_CMP2       3

// Prescale select codes
`define TOC_PRE_DIV4      2'h0
`define TOC_PRE_DIV2      2'h1
`define TOC_PRE_DIV8      2'h2
`define TOC_PRE_EXT       2'h3
`define TOC_MASK_DIV2     3'h1
`define TOC_MASK_DIV4     3'h3
`define TOC_MASK_DIV8     3'h7

// Reset and reload values
`define TOC_CMP_RESET     16'h8000
`define TOC_CNT_RELOAD    16'hFFFC
`define TOC_CAP_PULSE     16'hFFFD
`define TOC_CTRL_RESET    8'h00
`define TOC_ZERO16        16'h0000
`define TOC_ZERO8         8'h00

`endif

// file: verification/toc_pin_partner.sv
// Model of the circuitry driving the capture and external clock pins
`timescale 1ns/1ps

module toc_pin_partner (
	// Clock
	input  wire  hclk,
	// Pins toward the timer
	output logic capture_input_pin_one,
	output logic capture_input_pin_two,
	output logic ext_clock_pin
);
	// External clock stays quiet: only the internal prescaler is used
	initial begin
		capture_input_pin_one = 1'b0;
		capture_input_pin_two = 1'b0;
		ext_clock_pin = 1'b0;
	end

	// Clean high pulse, held long enough to cross the pin synchroniser
	task automatic pulse(input int ch, input int len);
		@(posedge hclk);
		if (ch == 1)
			capture_input_pin_one <= 1'b1;
		else
			capture_input_pin_two <= 1'b1;
		repeat (len) @(posedge hclk);
		capture_input_pin_one <= 1'b0;
		capture_input_pin_two <= 1'b0;
	endtask
endmodule // toc_pin_partner

// file: verification/toc_timer_compare_monitor.sv
// Checker of bus, pin and interrupt relations of the timer compare block
`timescale 1ns/1ps

module toc_timer_compare_chk (
	// Clock and reset
	input wire        hclk,
	input wire        hresetn,
	// Bus
	input wire        hsel,
	input wire [7:0]  haddr,
	input wire [1:0]  htrans,
	input wire        hwrite,
	input wire [31:0] hwdata,
	input wire        hready,
	input wire        hreadyout,
	input wire        hresp,
	input wire [31:0] hrdata,
	// Pins and mask
	input wire        capture_input_pin_one,
	input wire        cpu_irq_mask,
	input wire        compare_output_pin_one,
	input wire        compare_output_pin_one_oe,
	input wire        compare_output_pin_two,
	input wire        compare_output_pin_two_oe,
	input wire        timer_irq_reg
);
	logic       wr_dp, one_pulse_select, ctl1_wr, ctl2_wr;
	logic [7:0] dp_addr, c1_reg, c2_reg;

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// Either mode that locks out the forced levels
	assign one_pulse_select     = c2_reg[5] | c2_reg[4];
	assign ctl1_wr = wr_dp && dp_addr == 8'h04;
	assign ctl2_wr = wr_dp && dp_addr == 8'h00;

	////////////////////////////////////////////////////////////////////////
	// Control shadow, updated at the data phase edge like the design
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_dp   <= 1'b0;
			dp_addr <= 8'h00;
			c1_reg  <= 8'h00;
			c2_reg  <= 8'h00;
		end else begin
			wr_dp   <= hsel && htrans[1] && hready && hwrite;
			dp_addr <= haddr;
			if (ctl1_wr)
				c1_reg <= hwdata[7:0];
			if (ctl2_wr)
				c2_reg <= hwdata[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	ready_high_a: assert property (hreadyout && !hresp)
		else $error("bus not ready or not okay");
	rdata_upper_a: assert property (hrdata[31:8] == 24'h000000)
		else $error("read data upper bits not zero");
	rdata_hold_a: assert property (
		!(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
		else $error("read data changed without a read");
	pin_reset_a: assert property (disable iff (1'b0) !hresetn |->
		!compare_output_pin_one && !compare_output_pin_two)
		else $error("compare pin not low in reset");
	irq_mask_a: assert property (cpu_irq_mask |=> !timer_irq_reg)
		else $error("interrupt raised while masked");
	pin_enable_a: assert property (ctl2_wr |-> ##2
		compare_output_pin_one_oe == $past(hwdata[7], 2) &&
		compare_output_pin_two_oe == $past(hwdata[6], 2))
		else $error("pin enable not followed");
	force_copy_a: assert property (ctl1_wr && hwdata[3] && !one_pulse_select |->
		##2 compare_output_pin_one == $past(hwdata[0], 2))
		else $error("forced level not copied");
	force_ignore_a: assert property (ctl1_wr && hwdata[3] && one_pulse_select |->
		##1 $stable(compare_output_pin_one) [*2])
		else $error("forced level acted in pulse mode");
	pulse_start_a: assert property ($rose(capture_input_pin_one) &&
		c2_reg[5] && !c2_reg[4] && c1_reg[1] |->
		##[3:8] compare_output_pin_one == c1_reg[2])
		else $error("pulse did not start");

	cover property (ctl1_wr && hwdata[3]);
	cover property ($rose(timer_irq_reg));
	cover property ($rose(capture_input_pin_one) && c2_reg[5]);
endmodule // toc_timer_compare_chk

bind toc_timer_compare toc_timer_compare_chk u_chk (
	.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
	.hreadyout, .hresp, .hrdata, .capture_input_pin_one, .cpu_irq_mask,
	.compare_output_pin_one, .compare_output_pin_one_oe,
	.compare_output_pin_two, .compare_output_pin_two_oe, .timer_irq_reg
);

// file: verification/toc_timer_compare_tb.sv
// Self-checking bench of the timer compare block
`timescale 1ns/1ps
`include "toc_timer_regs.vh"

module toc_timer_compare_tb;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic        cpu_irq_mask, rd_dp, pin_one, oe_one, pin_two, oe_two, irq;
	logic [1:0]  htrans;
	logic [7:0]  haddr;
	logic [31:0] hwdata, hrdata;
	wire         cap_one, cap_two, ext_clk;
	logic [31:0] exp_q[$];
	int          miscompares, tests_run;
	logic [7:0]  frc_val[4] = '{8'h18, 8'h0D, 8'h14, 8'h18};
	logic        frc_p1[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
	logic        frc_p2[4] = '{1'b0, 1'b0, 1'b1, 1'b0};
	logic [7:0]  rst_adr[8] = '{`TOC_OFF_CMP1_HI, `TOC_OFF_CMP1_LO,
		`TOC_OFF_CMP2_HI, `TOC_OFF_CMP2_LO, `TOC_OFF_STATUS,
		`TOC_OFF_CTRL_ONE, `TOC_OFF_CTRL_TWO, 8'hFC};
	logic [7:0]  rst_val[8] = '{8'h80, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00};

	toc_timer_compare uut (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
		.hsize(3'h2), .hready(hreadyout), .hreadyout, .hresp, .hrdata,
		.capture_input_pin_one(cap_one), .capture_input_pin_two(cap_two),
		.ext_clock_pin(ext_clk), .cpu_irq_mask,
		.compare_output_pin_one(pin_one),
		.compare_output_pin_one_oe(oe_one),
		.compare_output_pin_two(pin_two),
		.compare_output_pin_two_oe(oe_two),
		.timer_irq_reg(irq)
	);

	toc_pin_partner u_pins (
		.hclk, .capture_input_pin_one(cap_one),
		.capture_input_pin_two(cap_two), .ext_clock_pin(ext_clk)
	);

	always #10 hclk = ~hclk;

	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		tests_run++;
		if (seen !== want) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask

	task automatic pin_chk(input logic seen, input logic want);
		check({31'h0, seen}, {31'h0, want});
	endtask

	task automatic finish_test();
		if (miscompares == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Bounded wait on the bus ready (pin low) or on compare pin one
	task automatic wait_for(input logic pin, input logic v, input int lim);
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
			if (n > lim) begin
				miscompares++;
				finish_test();
			end
		end while ((pin ? pin_one : hreadyout) !== v);
	endtask

	// Upper data bits are random: the block must ignore them
	task automatic xfer(input logic wr, input logic [7:0] a,
		input logic [7:0] d);
		logic [31:0] r;
		r = $urandom();
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= a;
		hwrite <= wr;
		wait_for(1'b0, 1'b1, 50);
		htrans <= 2'h0;
		hwdata <= {r[31:8], d};
		wait_for(1'b0, 1'b1, 50);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back({24'h000000, e});
		xfer(1'b0, a, 8'h00);
	endtask

	// Read data is taken at the data phase edge against the oldest note
	always @(posedge hclk) begin
		if (rd_dp && exp_q.size() > 0)
			check(hrdata, exp_q.pop_front());
		rd_dp <= hsel && htrans[1] && hreadyout && !hwrite;
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 8'h00;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h00000000;
		cpu_irq_mask = 1'b0;
		rd_dp = 1'b0;
		miscompares = 0;
		tests_run = 0;
		void'($urandom(32'h689045E4));
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		foreach (rst_adr[k])
			rd(rst_adr[k], rst_val[k]);
		// Channel one match, with the safe update order
		wr(`TOC_OFF_CTRL_ONE, 8'h41);
		wr(`TOC_OFF_CTRL_TWO, 8'h84);
		wr(`TOC_OFF_CMP1_HI, 8'h00);
		rd(`TOC_OFF_STATUS, 8'h00);
		wr(`TOC_OFF_CMP1_LO, 8'h10);
		wr(`TOC_OFF_CNT_LO, 8'h00);
		rd(`TOC_OFF_CNT_HI, 8'hFF);
		wait_for(1'b1, 1'b1, 200);
		repeat (2) @(posedge hclk);
		pin_chk(irq, 1'b1);
		cpu_irq_mask <= 1'b1;
		repeat (2) @(posedge hclk);
		pin_chk(irq, 1'b0);
		cpu_irq_mask <= 1'b0;
		rd(`TOC_OFF_CMP1_LO, 8'h10);
		rd(`TOC_OFF_STATUS, 8'h40);
		rd(`TOC_OFF_CMP1_LO, 8'h10);
		rd(`TOC_OFF_STATUS, 8'h00);
		pin_chk(irq, 1'b0);
		// Pending high bytes hold both channels off; pin two not enabled
		wr(`TOC_OFF_CTRL_ONE, 8'h45);
		wr(`TOC_OFF_CMP1_HI, 8'h40);
		wr(`TOC_OFF_CMP2_HI, 8'h00);
		wr(`TOC_OFF_CNT_LO, 8'h00);
		repeat (60) @(posedge hclk);
		rd(`TOC_OFF_STATUS, 8'h00);
		wr(`TOC_OFF_CMP2_LO, 8'h30);
		repeat (80) @(posedge hclk);
		rd(`TOC_OFF_STATUS, 8'h08);
		pin_chk(pin_two, 1'b0);
		pin_chk(oe_two, 1'b0);
		pin_chk(irq, 1'b1);
		rd(`TOC_OFF_CMP2_LO, 8'h30);
		rd(`TOC_OFF_STATUS, 8'h00);
		// Forced levels reach the pins with no flag and no interrupt
		foreach (frc_val[k]) begin
			wr(`TOC_OFF_CTRL_ONE, frc_val[k]);
			repeat (2) @(posedge hclk);
			pin_chk(pin_one, frc_p1[k]);
			pin_chk(pin_two, frc_p2[k]);
			rd(`TOC_OFF_STATUS, 8'h00);
			pin_chk(irq, 1'b0);
			rd(`TOC_OFF_CTRL_ONE, frc_val[k] & `TOC_C1_RD_MASK);
		end
		// One pulse: trigger raises level two, compare one ends it
		wr(`TOC_OFF_CMP1_HI, 8'h00);
		wr(`TOC_OFF_CMP1_LO, 8'h08);
		wr(`TOC_OFF_CTRL_ONE, 8'h86);
		wr(`TOC_OFF_CTRL_TWO, 8'hE6);
		wr(`TOC_OFF_CTRL_ONE, 8'h8F);
		repeat (2) @(posedge hclk);
		pin_chk(pin_one, 1'b0);
		wr(`TOC_OFF_CTRL_ONE, 8'h86);
		u_pins.pulse(1, 8);
		wait_for(1'b1, 1'b1, 20);
		wait_for(1'b1, 1'b0, 100);
		repeat (120) @(posedge hclk);
		rd(`TOC_OFF_STATUS, 8'h88);
		pin_chk(irq, 1'b1);
		pin_chk(pin_two, 1'b0);
		rd(`TOC_OFF_CAP1_HI, 8'hFF);
		rd(`TOC_OFF_CAP1_LO, 8'hFD);
		rd(`TOC_OFF_STATUS, 8'h08);
		u_pins.pulse(2, 8);
		repeat (4) @(posedge hclk);
		rd(`TOC_OFF_STATUS, 8'h18);
		finish_test();
	end
endmodule // toc_timer_compare_tb
